// *** inc/pdsm_consts.svh ***
// constants for the program/data space mapper
`ifndef PDSM_CONSTS_SVH
`define PDSM_CONSTS_SVH
`define PM_W          24
`define D_W           16
`define EA_W          16
`define PAGE_W        8
`define WORD_ADDR_W   15
`define WIN_BIT       15
`define WIN_LOW_HI    14
`define CFG_SPACE_BIT 7
`define Y_FIRST       16'h0800
`define Y_LAST        16'h0BFF
`define RAM_FIRST     16'h0000
`define RAM_LAST      16'h0BFF
`define ZERO_WORD     16'h0000
`define ZERO_BYTE     8'h00
`define OFS_CTRL      8'h00
`define OFS_WIN_PAGE  8'h04
`define OFS_TBL_PAGE  8'h08
`define OFS_STATUS    8'h0C
`define CTRL_WIN_EN   0
`define RST_PAGE      8'h00
`define RST_WORD      32'h0000_0000
`define BE_LOW        2'h1
`define BE_HIGH       2'h2
`define BE_WORD       2'h3
`define EXTRA_NONE    2'h0
`define EXTRA_ONE     2'h1
`define EXTRA_TWO     2'h2
`endif

// *** inc/pdsm_pkg.sv ***
// types shared by the mapper and its read formatter
package pdsm_pkg;
  typedef enum logic [1:0] {
    acc_data,
    acc_window,
    acc_tbl_low,
    acc_tbl_high
  } access_kind_t;
  typedef enum logic [1:0] {
    ic_mac_prefetch,
    ic_move,
    ic_double_move,
    ic_other
  } instr_class_t;
  typedef enum logic [1:0] {
    tbl_read_low,
    tbl_read_high,
    tbl_write_low,
    tbl_write_high
  } tbl_op_t;
endpackage

// *** inc/read_path_if.sv ***
// carrier between the mapper and its read formatter
`timescale 1ns/100ps
`include "pdsm_consts.svh"
interface read_path_if;
  import pdsm_pkg::*;
  access_kind_t          kind;
  logic                  is_byte;
  logic                  byte_sel;
  logic                  force_zero;
  logic [`PM_W-1:0]      pm_word;
  logic [`D_W-1:0]       dm_word;
  logic [`D_W-1:0]       result;
  modport mapper (output kind, is_byte, byte_sel, force_zero, pm_word,
                  dm_word, input result);
  modport formatter (input kind, is_byte, byte_sel, force_zero, pm_word,
                     dm_word, output result);
endinterface

// *** hdl/read_formatter.sv ***
// shapes the returned word or byte for the x read path
`timescale 1ns/100ps
`include "pdsm_consts.svh"
module read_formatter
  import pdsm_pkg::*;
(
  read_path_if.formatter rp
);
  wire [`D_W-1:0] pm_low;
  wire [`D_W-1:0] pm_high;
  wire [`D_W-1:0] pm_sel;
  wire [`D_W-1:0] src;
  wire [7:0]      byte_pick;

  assign pm_low    = rp.pm_word[`D_W-1:0];
  assign pm_high   = {`ZERO_BYTE, rp.pm_word[`PM_W-1:`D_W]};
  assign pm_sel    = (rp.kind == acc_tbl_high) ? pm_high : pm_low;
  assign src       = (rp.kind == acc_data) ? rp.dm_word : pm_sel;
  assign byte_pick = rp.byte_sel ? src[`D_W-1:8] : src[7:0];
  assign rp.result = rp.force_zero ? `ZERO_WORD :
                     rp.is_byte    ? {`ZERO_BYTE, byte_pick} : src;
endmodule

// *** hdl/program_data_space_mapper.sv ***
// maps table, window and x/y data accesses onto program and data memory
`timescale 1ns/100ps
`include "pdsm_consts.svh"
module program_data_space_mapper
  import pdsm_pkg::*;
#(
  parameter logic [`EA_W-1:0] RAM_FIRST = `RAM_FIRST,
  parameter logic [`EA_W-1:0] RAM_LAST  = `RAM_LAST
)(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output wire logic                  hreadyout,
  output wire logic                  hresp,
  input  wire logic                  x_rd_valid,
  input  wire logic [`EA_W-1:0]      x_rd_ea,
  input  wire logic                  x_rd_byte,
  input  wire logic                  x_rd_mac,
  input  wire logic                  y_rd_valid,
  input  wire logic [`EA_W-1:0]      y_rd_ea,
  input  wire logic                  rd_bitrev,
  input  wire logic                  tbl_valid,
  input  wire tbl_op_t               tbl_op,
  input  wire logic                  tbl_byte,
  input  wire logic [`EA_W-1:0]      tbl_ea,
  input  wire logic [`D_W-1:0]       tbl_wdata,
  input  wire logic                  x_wr_valid,
  input  wire logic [`EA_W-1:0]      x_wr_ea,
  input  wire logic                  x_wr_byte,
  input  wire logic [`D_W-1:0]       x_wr_data,
  input  wire instr_class_t          instr_class,
  input  wire logic                  in_repeat,
  input  wire logic                  repeat_first,
  input  wire logic                  repeat_last,
  input  wire logic                  repeat_irq_exit,
  input  wire logic                  repeat_reentry,
  output logic      [`D_W-1:0]       x_rd_data,
  output logic                       x_rd_done,
  output logic      [`D_W-1:0]       y_rd_data,
  output logic                       y_rd_done,
  output logic      [1:0]            extra_cycles,
  output logic                       agu_mode_fault,
  output wire logic                  pm_rd,
  output wire logic [`PM_W-1:0]      pm_addr,
  output wire logic                  pm_cfg_space,
  input  wire logic [`PM_W-1:0]      pm_rdata,
  output wire logic                  dm_x_rd,
  output wire logic [`WORD_ADDR_W-1:0] dm_x_addr,
  input  wire logic [`D_W-1:0]       dm_x_rdata,
  output wire logic                  dm_y_rd,
  output wire logic [`WORD_ADDR_W-1:0] dm_y_addr,
  input  wire logic [`D_W-1:0]       dm_y_rdata,
  output logic                       dm_wr,
  output logic      [`WORD_ADDR_W-1:0] dm_wr_addr,
  output logic      [`D_W-1:0]       dm_wr_data,
  output logic      [1:0]            dm_wr_be,
  output logic                       flash_wr_valid,
  output logic                       flash_wr_high,
  output logic                       flash_wr_byte,
  output logic      [`PM_W-1:0]      flash_wr_addr,
  output logic      [`D_W-1:0]       flash_wr_data
);
  // software-visible control
  logic                 win_en;
  logic [`PAGE_W-1:0]   win_page;
  logic [`PAGE_W-1:0]   tbl_page;
  logic [15:0]          zero_count;
  logic                 last_window;
  // ahb data-phase latch
  logic                 dp_write;
  logic [7:0]           dp_ofs;
  // read pipeline stage
  logic                 s1_x_valid;
  access_kind_t         s1_kind;
  logic                 s1_byte;
  logic                 s1_bsel;
  logic                 s1_zero;
  logic [1:0]           s1_extra;
  logic                 s1_tbl;
  logic                 s1_y_valid;
  logic                 s1_y_zero;

  read_path_if rp ();

  read_formatter read_formatter_inst (
    .rp (rp.formatter)
  );

  // ---------------- ahb-lite slave ----------------
  wire       ahb_take  = hsel & hready & htrans[1];
  wire [7:0] ahb_ofs   = haddr[7:0];
  wire       hit_ctrl  = (ahb_ofs == `OFS_CTRL);
  wire       hit_wpage = (ahb_ofs == `OFS_WIN_PAGE);
  wire       hit_tpage = (ahb_ofs == `OFS_TBL_PAGE);
  wire       hit_stat  = (ahb_ofs == `OFS_STATUS);
  wire       tbl_busy  = tbl_valid | s1_tbl;
  wire [31:0] rd_mux =
    hit_ctrl  ? {31'h0000_0000, win_en} :
    hit_wpage ? {24'h00_0000, win_page} :
    hit_tpage ? {24'h00_0000, tbl_page} :
    hit_stat  ? {zero_count, 14'h0000, last_window, tbl_busy} :
                `RST_WORD;
  wire dp_commit = dp_write & hready;

  // zero-wait slave, every answer is okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_ofs   <= `ZERO_BYTE;
      hrdata   <= `RST_WORD;
    end else begin
      if (hready) begin
        dp_write <= ahb_take & hwrite;
        dp_ofs   <= ahb_ofs;
      end
      if (ahb_take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_en   <= 1'b0;
      win_page <= `RST_PAGE;
      tbl_page <= `RST_PAGE;
    end else if (dp_commit) begin
      if (dp_ofs == `OFS_CTRL) begin
        win_en <= hwdata[`CTRL_WIN_EN];
      end else if (dp_ofs == `OFS_WIN_PAGE) begin
        win_page <= hwdata[`PAGE_W-1:0];
      end else if (dp_ofs == `OFS_TBL_PAGE) begin
        tbl_page <= hwdata[`PAGE_W-1:0];
      end
    end
  end

  // ---------------- address mapping ----------------
  wire tbl_read  = tbl_valid &
                   ((tbl_op == tbl_read_low) | (tbl_op == tbl_read_high));
  wire tbl_write = tbl_valid & ~tbl_read;
  wire window_on = x_rd_valid & win_en & x_rd_ea[`WIN_BIT] & ~tbl_busy;
  wire x_data_rd = x_rd_valid & ~window_on & ~tbl_valid;

  wire x_in_ram  = (x_rd_ea >= RAM_FIRST) & (x_rd_ea <= RAM_LAST);
  wire x_in_y    = (x_rd_ea >= `Y_FIRST) & (x_rd_ea <= `Y_LAST);
  wire y_in_y    = (y_rd_ea >= `Y_FIRST) & (y_rd_ea <= `Y_LAST);
  wire w_in_ram  = (x_wr_ea >= RAM_FIRST) & (x_wr_ea <= RAM_LAST);
  wire x_bad     = ~x_in_ram | (x_rd_mac & x_in_y);
  wire x_zero    = ~window_on & x_bad;

  wire [`PM_W-1:0] tbl_pm_addr = {tbl_page, tbl_ea};
  wire [`PM_W-1:0] win_pm_addr = {1'b0, win_page,
                                  x_rd_ea[`WIN_LOW_HI:0]};

  assign pm_rd        = tbl_read | window_on;
  assign pm_addr      = tbl_valid ? tbl_pm_addr : win_pm_addr;
  assign pm_cfg_space = tbl_valid & tbl_page[`CFG_SPACE_BIT];
  assign dm_x_rd      = x_data_rd & ~x_bad;
  assign dm_x_addr    = x_rd_ea[`EA_W-1:1];
  assign dm_y_rd      = y_rd_valid & y_in_y;
  assign dm_y_addr    = y_rd_ea[`EA_W-1:1];

  wire light_class = (instr_class == ic_mac_prefetch) |
                     (instr_class == ic_move) |
                     (instr_class == ic_double_move);
  wire [1:0] cost_out = light_class ? `EXTRA_ONE : `EXTRA_TWO;
  wire repeat_edge = repeat_first | repeat_last |
                     repeat_irq_exit | repeat_reentry;
  wire [1:0] cost_in  = repeat_edge ? `EXTRA_TWO : `EXTRA_NONE;
  wire [1:0] next_extra = !window_on ? `EXTRA_NONE :
                          in_repeat  ? cost_in : cost_out;

  wire access_kind_t next_kind =
    tbl_read  ? ((tbl_op == tbl_read_high) ? acc_tbl_high : acc_tbl_low) :
    window_on ? acc_window : acc_data;
  wire next_byte = tbl_read ? tbl_byte : x_rd_byte;
  wire next_bsel = tbl_read ? tbl_ea[0] : x_rd_ea[0];

  // ---------------- read pipeline ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_x_valid <= 1'b0;
      s1_kind    <= acc_data;
      s1_byte    <= 1'b0;
      s1_bsel    <= 1'b0;
      s1_zero    <= 1'b0;
      s1_extra   <= `EXTRA_NONE;
      s1_tbl     <= 1'b0;
      s1_y_valid <= 1'b0;
      s1_y_zero  <= 1'b0;
    end else begin
      s1_x_valid <= tbl_read | x_rd_valid;
      s1_kind    <= next_kind;
      s1_byte    <= next_byte;
      s1_bsel    <= next_bsel;
      s1_zero    <= ~tbl_read & x_zero;
      s1_extra   <= next_extra;
      s1_tbl     <= tbl_valid;
      s1_y_valid <= y_rd_valid;
      s1_y_zero  <= ~y_in_y;
    end
  end

  assign rp.kind       = s1_kind;
  assign rp.is_byte    = s1_byte;
  assign rp.byte_sel   = s1_bsel;
  assign rp.force_zero = s1_zero;
  assign rp.pm_word    = pm_rdata;
  assign rp.dm_word    = dm_x_rdata;

  wire [`D_W-1:0] next_y_data = s1_y_zero ? `ZERO_WORD : dm_y_rdata;
  wire zero_hit = (s1_x_valid & s1_zero) | (s1_y_valid & s1_y_zero);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      x_rd_data    <= `ZERO_WORD;
      x_rd_done    <= 1'b0;
      y_rd_data    <= `ZERO_WORD;
      y_rd_done    <= 1'b0;
      extra_cycles <= `EXTRA_NONE;
      zero_count   <= `ZERO_WORD;
      last_window  <= 1'b0;
    end else begin
      x_rd_done    <= s1_x_valid;
      y_rd_done    <= s1_y_valid;
      extra_cycles <= s1_extra;
      if (s1_x_valid) begin
        x_rd_data   <= rp.result;
        last_window <= (s1_kind == acc_window);
      end
      if (s1_y_valid) begin
        y_rd_data <= next_y_data;
      end
      if (zero_hit) begin
        zero_count <= zero_count + 16'h0001;
      end
    end
  end

  // ---------------- writes ----------------
  // single x write bus
  wire w_ok = x_wr_valid & w_in_ram;
  wire [1:0] next_be = !x_wr_byte ? `BE_WORD :
                       x_wr_ea[0] ? `BE_HIGH : `BE_LOW;
  wire [`D_W-1:0] next_wdata = x_wr_byte ? {2{x_wr_data[7:0]}} : x_wr_data;
  wire next_fault = rd_bitrev & (x_rd_valid | y_rd_valid);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dm_wr          <= 1'b0;
      dm_wr_addr     <= 15'h0000;
      dm_wr_data     <= `ZERO_WORD;
      dm_wr_be       <= `BE_WORD;
      agu_mode_fault <= 1'b0;
    end else begin
      dm_wr          <= w_ok;
      dm_wr_addr     <= x_wr_ea[`EA_W-1:1];
      dm_wr_data     <= next_wdata;
      dm_wr_be       <= next_be;
      agu_mode_fault <= next_fault;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_wr_valid <= 1'b0;
      flash_wr_high  <= 1'b0;
      flash_wr_byte  <= 1'b0;
      flash_wr_addr  <= 24'h00_0000;
      flash_wr_data  <= `ZERO_WORD;
    end else begin
      flash_wr_valid <= tbl_write;
      flash_wr_high  <= (tbl_op == tbl_write_high);
      flash_wr_byte  <= tbl_byte;
      flash_wr_addr  <= tbl_pm_addr;
      flash_wr_data  <= tbl_wdata;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  tbl_low_word_a: assert property (
    tbl_valid && tbl_op == tbl_read_low && !tbl_byte
    |-> ##2 x_rd_done && x_rd_data == $past(pm_rdata[15:0]))
    else $error("table low word not returned");
  tbl_high_zero_a: assert property (
    tbl_valid && tbl_op == tbl_read_high
    |-> ##2 x_rd_data[15:8] == `ZERO_BYTE)
    else $error("table high upper byte not zero");
  tbl_addr_a: assert property (
    tbl_valid |-> pm_addr == {tbl_page, tbl_ea})
    else $error("table program address wrong");
  win_addr_a: assert property (
    window_on |-> pm_rd && pm_addr[22:0] == {win_page, x_rd_ea[14:0]})
    else $error("window program address wrong");
  win_suspend_a: assert property (
    tbl_valid ##1 x_rd_valid |-> !window_on)
    else $error("window active during table op");
  win_gate_a: assert property (
    x_rd_valid && !x_rd_ea[15] |-> !window_on)
    else $error("window opened below upper half");
  mac_zero_a: assert property (
    x_rd_valid && x_rd_mac && x_in_y && !tbl_busy
    |-> ##2 x_rd_data == `ZERO_WORD)
    else $error("mac x pointer into y not zero");
  y_zero_a: assert property (
    y_rd_valid && !y_in_y |-> !dm_y_rd ##2 y_rd_done && y_rd_data == 0)
    else $error("y pointer outside y not zero");
  cost_a: assert property (
    window_on && !in_repeat && instr_class == ic_move
    |-> ##2 extra_cycles == `EXTRA_ONE)
    else $error("window cost outside repeat wrong");
  flash_fwd_a: assert property (
    tbl_valid && tbl_op == tbl_write_low
    |=> flash_wr_valid && flash_wr_data == $past(tbl_wdata))
    else $error("table write not forwarded");
endmodule

// *** testbench/mem_model.sv ***
// behavioural program and data memory behind the mapper, data computed from the address
`timescale 1ns/100ps
`include "pdsm_consts.svh"
module mem_model (
  input  wire logic                    hclk,
  input  wire logic                    pm_rd,
  input  wire logic [`PM_W-1:0]        pm_addr,
  output logic      [`PM_W-1:0]        pm_rdata,
  input  wire logic                    dm_x_rd,
  input  wire logic [`WORD_ADDR_W-1:0] dm_x_addr,
  output logic      [`D_W-1:0]         dm_x_rdata,
  input  wire logic                    dm_y_rd,
  input  wire logic [`WORD_ADDR_W-1:0] dm_y_addr,
  output logic      [`D_W-1:0]         dm_y_rdata
);
  function automatic logic [`PM_W-1:0] pm_val(logic [`PM_W-1:0] a);
    return {a[7:0] ^ 8'hc3, a[15:0] ^ 16'h9e37};
  endfunction
  function automatic logic [`D_W-1:0] dm_val(logic [`WORD_ADDR_W-1:0] a);
    return {a, 1'b1} ^ 16'h0ff0;
  endfunction
  initial begin
    pm_rdata = 24'h00_0000;
    dm_x_rdata = 16'h0000;
    dm_y_rdata = 16'h0000;
  end
  // idle cycles show the inverse so stale data never passes for a read
  always @(posedge hclk) begin
    // words sit at even addresses; bit 0 only picks a byte
    pm_rdata   <= pm_rd ? pm_val({pm_addr[`PM_W-1:1], 1'b0}) : ~pm_rdata;
    dm_x_rdata <= dm_x_rd ? dm_val(dm_x_addr) : ~dm_x_rdata;
    dm_y_rdata <= dm_y_rd ? dm_val(dm_y_addr) : ~dm_y_rdata;
  end
endmodule

// *** testbench/tb_program_data_space_mapper.sv ***
// self-checking bench for the program/data space mapper
`timescale 1ns/100ps
`include "pdsm_consts.svh"
module tb_program_data_space_mapper
  import pdsm_pkg::*;
;
  logic         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic         x_rd_valid = 1'b0, x_rd_byte = 1'b0, x_rd_mac = 1'b0;
  logic         y_rd_valid = 1'b0, rd_bitrev = 1'b0, tbl_valid = 1'b0;
  logic         tbl_byte = 1'b0, x_wr_valid = 1'b0, x_wr_byte = 1'b0;
  logic         in_repeat = 1'b0, repeat_first = 1'b0, repeat_last = 1'b0;
  logic         repeat_irq_exit = 1'b0, repeat_reentry = 1'b0;
  logic [31:0]  haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic [2:0]   hsize = 3'h2;
  logic [15:0]  x_rd_ea = 16'h0, y_rd_ea = 16'h0, tbl_ea = 16'h0;
  logic [15:0]  tbl_wdata = 16'h0, x_wr_ea = 16'h0, x_wr_data = 16'h0;
  tbl_op_t      tbl_op = tbl_read_low;
  instr_class_t instr_class = ic_other;
  wire logic [31:0] hrdata;
  wire logic        hreadyout, hresp, x_rd_done, y_rd_done, agu_mode_fault;
  wire logic        pm_rd, pm_cfg_space, dm_x_rd, dm_y_rd, dm_wr;
  wire logic        flash_wr_valid, flash_wr_high, flash_wr_byte;
  wire logic [1:0]  extra_cycles, dm_wr_be;
  wire logic [23:0] pm_addr, pm_rdata, flash_wr_addr;
  wire logic [14:0] dm_x_addr, dm_y_addr, dm_wr_addr;
  wire logic [15:0] x_rd_data, y_rd_data, dm_wr_data, flash_wr_data;
  wire logic [15:0] dm_x_rdata, dm_y_rdata;
  int               n_fail = 0;
  int               checks = 0;

  always #4 hclk = ~hclk;

  program_data_space_mapper program_data_space_mapper_inst (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .x_rd_valid, .x_rd_ea, .x_rd_byte,
    .x_rd_mac, .y_rd_valid, .y_rd_ea, .rd_bitrev, .tbl_valid, .tbl_op,
    .tbl_byte, .tbl_ea, .tbl_wdata, .x_wr_valid, .x_wr_ea, .x_wr_byte,
    .x_wr_data, .instr_class, .in_repeat, .repeat_first, .repeat_last,
    .repeat_irq_exit, .repeat_reentry, .x_rd_data, .x_rd_done, .y_rd_data,
    .y_rd_done, .extra_cycles, .agu_mode_fault, .pm_rd, .pm_addr,
    .pm_cfg_space, .pm_rdata, .dm_x_rd, .dm_x_addr, .dm_x_rdata, .dm_y_rd,
    .dm_y_addr, .dm_y_rdata, .dm_wr, .dm_wr_addr, .dm_wr_data, .dm_wr_be,
    .flash_wr_valid, .flash_wr_high, .flash_wr_byte, .flash_wr_addr,
    .flash_wr_data);

  mem_model mem_model_inst (.hclk, .pm_rd, .pm_addr, .pm_rdata, .dm_x_rd,
    .dm_x_addr, .dm_x_rdata, .dm_y_rd, .dm_y_addr, .dm_y_rdata);

  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic wait_rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && i < 20) begin
      @(posedge hclk);
      i++;
    end
    if (i == 20) begin
      n_fail++;
      stop_test;
    end
  endtask

  // one single word transfer; starts and ends right after a rising edge
  task automatic ahb(logic wr, logic [7:0] a, logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask

  task automatic rd_end(logic [15:0] e, logic [1:0] ex);
    @(posedge hclk);
    x_rd_valid <= 1'b0;
    tbl_valid  <= 1'b0;
    @(posedge hclk);
    #1;
    chk("x done", 32'h1, x_rd_done);
    chk("x data", e, x_rd_data);
    chk("extra", ex, extra_cycles);
    @(posedge hclk);
  endtask

  task automatic xrd(logic [15:0] ea, logic byt, logic mac, instr_class_t ic,
                     logic w, logic [15:0] e, logic [1:0] ex);
    x_rd_valid  <= 1'b1;
    x_rd_ea     <= ea;
    x_rd_byte   <= byt;
    x_rd_mac    <= mac;
    instr_class <= ic;
    #1;
    chk("pm_rd", w, pm_rd);
    if (w) chk("win addr", {1'b0, 8'h5a, ea[14:0]}, pm_addr);
    rd_end(e, ex);
  endtask

  task automatic tread(tbl_op_t op, logic byt, logic [15:0] ea);
    logic [23:0] pw;
    logic [15:0] e;
    pw = mem_model_inst.pm_val({8'h81, ea[15:1], 1'b0});
    if (op == tbl_read_low) begin
      e = byt ? {8'h00, ea[0] ? pw[15:8] : pw[7:0]} : pw[15:0];
    end else begin
      e = (byt && ea[0]) ? 16'h0000 : {8'h00, pw[23:16]};
    end
    tbl_valid <= 1'b1;
    tbl_op    <= op;
    tbl_byte  <= byt;
    tbl_ea    <= ea;
    #1;
    chk("tbl addr", {8'h81, ea}, pm_addr);
    chk("cfg space", 32'h1, pm_cfg_space);
    rd_end(e, 2'h0);
  endtask

  task automatic yrd(logic [15:0] ea, logic [15:0] e);
    y_rd_valid <= 1'b1;
    y_rd_ea    <= ea;
    @(posedge hclk);
    y_rd_valid <= 1'b0;
    @(posedge hclk);
    #1;
    chk("y done", 32'h1, y_rd_done);
    chk("y data", e, y_rd_data);
    @(posedge hclk);
  endtask

  task automatic regs_test;
    logic [31:0] r;
    logic [7:0]  ofs [4] = '{`OFS_CTRL, `OFS_WIN_PAGE, `OFS_TBL_PAGE, 8'h10};
    logic [31:0] val [4] = '{32'h0000_0001, 32'h0000_005a, 32'h0000_0081,
                             32'hffff_ffff};
    for (int k = 0; k < 4; k++) begin
      ahb(1'b0, ofs[k], 32'h0, r);
      chk("reg reset", 32'h0, r);
      ahb(1'b1, ofs[k], val[k], r);
      ahb(1'b0, ofs[k], 32'h0, r);
      chk("reg back", k < 3 ? val[k] : 32'h0, r);
    end
  endtask

  task automatic win_test;
    logic [31:0] r;
    logic [23:0] pw;
    logic [15:0] pl;
    pw = mem_model_inst.pm_val({1'b0, 8'h5a, 15'h1234});
    pl = pw[15:0];
    for (int k = 0; k < 4; k++) begin
      xrd(16'h9234, 1'b0, k == 0, instr_class_t'(k), 1'b1, pl,
          k == 3 ? 2'h2 : 2'h1);
    end
    in_repeat <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      {repeat_first, repeat_last, repeat_irq_exit, repeat_reentry} <= 4'h8 >> k;
      xrd(16'h9234, 1'b0, 1'b0, ic_move, 1'b1, pl,
          k < 4 ? 2'h2 : 2'h0);
    end
    in_repeat <= 1'b0;
    // a window read right behind a table read must not be redirected
    tbl_valid <= 1'b1;
    tbl_op    <= tbl_read_low;
    tbl_ea    <= 16'h0002;
    @(posedge hclk);
    tbl_valid <= 1'b0;
    xrd(16'h9234, 1'b0, 1'b0, ic_move, 1'b0, 16'h0000, 2'h0);
    ahb(1'b1, `OFS_CTRL, 32'h0, r);
    xrd(16'h9234, 1'b0, 1'b0, ic_move, 1'b0, 16'h0000, 2'h0);
  endtask

  task automatic space_test;
    logic [15:0] d;
    d = mem_model_inst.dm_val(15'h0480);
    xrd(16'h0900, 1'b0, 1'b0, ic_other, 1'b0, d, 2'h0);
    xrd(16'h0901, 1'b1, 1'b0, ic_other, 1'b0, {8'h00, d[15:8]}, 2'h0);
    xrd(16'h0900, 1'b0, 1'b1, ic_mac_prefetch, 1'b0, 16'h0, 2'h0);
    xrd(16'h0100, 1'b0, 1'b1, ic_mac_prefetch, 1'b0,
        mem_model_inst.dm_val(15'h0080), 2'h0);
    xrd(16'h0c00, 1'b0, 1'b0, ic_other, 1'b0, 16'h0, 2'h0);
    yrd(16'h0900, d);
    yrd(16'h0100, 16'h0000);
  endtask

  task automatic wr_test;
    logic        f;
    logic [31:0] r;
    x_wr_valid <= 1'b1;
    x_wr_ea    <= 16'h0102;
    x_wr_data  <= 16'h1234;
    @(posedge hclk);
    x_wr_ea    <= 16'h0103;
    x_wr_byte  <= 1'b1;
    x_wr_data  <= 16'h00ab;
    #1;
    chk("wr word addr", {16'h0000, 1'b1, 15'h0081},
        {16'h0000, dm_wr, dm_wr_addr});
    chk("wr word data", {14'h0000, 2'h3, 16'h1234},
        {14'h0000, dm_wr_be, dm_wr_data});
    @(posedge hclk);
    x_wr_ea    <= 16'h9000;
    x_wr_byte  <= 1'b0;
    #1;
    chk("wr byte addr", {16'h0000, 1'b1, 15'h0081},
        {16'h0000, dm_wr, dm_wr_addr});
    chk("wr byte data", {14'h0000, 2'h2, 16'habab},
        {14'h0000, dm_wr_be, dm_wr_data});
    @(posedge hclk);
    x_wr_valid <= 1'b0;
    tbl_valid  <= 1'b1;
    tbl_op     <= tbl_write_high;
    tbl_byte   <= 1'b1;
    tbl_ea     <= 16'h0246;
    tbl_wdata  <= 16'h5678;
    #1;
    chk("wr window", 32'h0, dm_wr);
    @(posedge hclk);
    tbl_op     <= tbl_write_low;
    tbl_byte   <= 1'b0;
    tbl_wdata  <= 16'h9abc;
    #1;
    chk("flash high", {5'h00, 3'h7, 24'h81_0246},
        {5'h00, flash_wr_valid, flash_wr_high, flash_wr_byte,
         flash_wr_addr});
    chk("flash high data", 32'h5678, flash_wr_data);
    @(posedge hclk);
    tbl_valid  <= 1'b0;
    rd_bitrev  <= 1'b1;
    x_rd_valid <= 1'b1;
    x_rd_ea    <= 16'h0100;
    #1;
    chk("flash low", {5'h00, 3'h4, 24'h81_0246},
        {5'h00, flash_wr_valid, flash_wr_high, flash_wr_byte,
         flash_wr_addr});
    chk("flash low data", 32'h9abc, flash_wr_data);
    @(posedge hclk);
    rd_bitrev  <= 1'b0;
    x_rd_valid <= 1'b0;
    f = 1'b0;
    repeat (3) begin
      #1;
      f = f | (agu_mode_fault === 1'b1);
      @(posedge hclk);
    end
    chk("bitrev read", 32'h1, f);
    // zero returns so far: two window-off x reads, three in space_test
    ahb(1'b0, `OFS_STATUS, 32'h0, r);
    chk("status", 32'h0005_0000, r);
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    regs_test;
    tread(tbl_read_low, 1'b0, 16'h0124);
    tread(tbl_read_low, 1'b1, 16'h0124);
    tread(tbl_read_low, 1'b1, 16'h0125);
    tread(tbl_read_high, 1'b0, 16'h0124);
    tread(tbl_read_high, 1'b1, 16'h0124);
    tread(tbl_read_high, 1'b1, 16'h0125);
    win_test;
    space_test;
    wr_test;
    stop_test;
  end

  // guard against a hang anywhere in the sequence
  initial begin
    #400000;
    n_fail++;
    stop_test;
  end
endmodule
